// ==== core/status_event_registers.v ====
// status event register bank: three read-clear event registers,
// answered as a decimal (bcd) value after a query and talk address.
// assumes event inputs are single-cycle or level signals on core_clk
// from internal logic; query and talk strobes come from the host decoder.
//
// Function
// - Three event registers exist, each read by its own query code.
// - After query then talk, the register value is returned in decimal digits.
// - A read clears every flag of the register read, except a flag whose set event is active in that cycle, as output bit 3 is while current limiting persists.
// - Acquisition bit 3 sets on a reading beyond the measurement range.
// - Acquisition bit 4 sets when an expected current pulse is missed.
// - Acquisition bit 5 sets when a reading is taken and processed.
// - Acquisition bit 9 sets when the averaging count has been collected.
// - Integrity bit 8 sets on an invalid calibration constant at power-up.
// - Integrity bit 8 clears when a calibration completes successfully.
// - Output bit 3 follows current limiting, set while limiting, clear after.
// - Output bit 4 sets on a limit trip and clears when output is re-enabled.
// - Output bit 5 sets on heat-sink shutdown and clears on re-enable.
// - Output bit 6 sets on an overload shutdown only; heat-sink shutdown sets bit 5.
// - Bits with no event always read as zero.
`timescale 1ns/100ps
`include "status_event_map.vh"

module status_event_registers (
  // clock and reset
  input  wire                core_clk,
  input  wire                rstn,
  // acquisition events
  input  wire                reading_overflow,
  input  wire                pulse_trigger_timeout,
  input  wire                reading_available,
  input  wire                average_count_done,
  // integrity events
  input  wire                cal_invalid_at_powerup,
  input  wire                cal_success,
  // output events
  input  wire                current_limiting,
  input  wire                limit_trip_off,
  input  wire                heat_sink_shutdown,
  input  wire                overload_shutdown,
  input  wire                output_reenable,
  // host query
  input  wire                query_valid,
  input  wire [1:0]          query_sel,
  input  wire                talk,
  // answer
  output reg                 answer_valid,
  output reg  [`DEC_W-1:0]   answer_bcd,
  output reg  [`EVT_W-1:0]   answer_bin,
  output reg                 query_bad
);

  reg  [`EVT_W-1:0]      acq_v;
  reg  [`EVT_W-1:0]      integ_v;
  reg  [`EVT_W-1:0]      outp_v;
  wire                   ovf_q;
  wire                   ptt_q;
  wire                   avail_q;
  wire                   avgdone_q;
  wire                   cal_q;
  wire                   limit_q;
  wire                   trip_q;
  wire                   heat_q;
  wire                   ovld_q;
  wire                   rd_acq;
  wire                   rd_integ;
  wire                   rd_outp;
  reg                    pend_q;
  reg  [1:0]             sel_q;
  reg                    conv_q;
  reg  [`CONV_CNT_W-1:0] cnt_q;
  reg  [`EVT_W-1:0]      shf_q;
  reg  [`DEC_W-1:0]      bcd_q;
  reg  [`DEC_W-1:0]      bcd_adj;
  reg  [`EVT_W-1:0]      snap;
  wire                   rd_go;
  integer                i;

  // read taken on talk while a query is pending, never beside a new query
  assign rd_go    = pend_q & talk & ~conv_q & ~query_valid;
  assign rd_acq   = rd_go & (sel_q == `QSEL_ACQ);
  assign rd_integ = rd_go & (sel_q == `QSEL_INTEG);
  assign rd_outp  = rd_go & (sel_q == `QSEL_OUTPUT);

  // selected register snapshot
  always @* begin
    case (sel_q)
      `QSEL_ACQ:    snap = acq_v;
      `QSEL_INTEG:  snap = integ_v;
      `QSEL_OUTPUT: snap = outp_v;
      default:      snap = `EVT_RESET;
    endcase
  end

  // acquisition flags
  // reading overflow
  event_flag_bit #(.CLEAR_WINS(0)) ovf_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (reading_overflow),
    .clr_ev   (1'b0),
    .rd_clr   (rd_acq),
    .flag_q   (ovf_q)
  );

  // missed current pulse
  event_flag_bit #(.CLEAR_WINS(0)) ptt_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (pulse_trigger_timeout),
    .clr_ev   (1'b0),
    .rd_clr   (rd_acq),
    .flag_q   (ptt_q)
  );

  // reading taken and processed
  event_flag_bit #(.CLEAR_WINS(0)) avail_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (reading_available),
    .clr_ev   (1'b0),
    .rd_clr   (rd_acq),
    .flag_q   (avail_q)
  );

  // averaging count collected
  event_flag_bit #(.CLEAR_WINS(0)) avgdone_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (average_count_done),
    .clr_ev   (1'b0),
    .rd_clr   (rd_acq),
    .flag_q   (avgdone_q)
  );

  // integrity flags
  // invalid calibration, cleared by a good calibration
  event_flag_bit #(.CLEAR_WINS(1)) cal_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (cal_invalid_at_powerup),
    .clr_ev   (cal_success),
    .rd_clr   (rd_integ),
    .flag_q   (cal_q)
  );

  // output flags
  // live follower of current limiting
  event_flag_bit #(.CLEAR_WINS(0)) limit_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (current_limiting),
    .clr_ev   (~current_limiting),
    .rd_clr   (rd_outp),
    .flag_q   (limit_q)
  );

  // limit trip, cleared on re-enable
  event_flag_bit #(.CLEAR_WINS(1)) trip_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (limit_trip_off),
    .clr_ev   (output_reenable),
    .rd_clr   (rd_outp),
    .flag_q   (trip_q)
  );

  // heat-sink shutdown, cleared on re-enable
  event_flag_bit #(.CLEAR_WINS(1)) heat_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (heat_sink_shutdown),
    .clr_ev   (output_reenable),
    .rd_clr   (rd_outp),
    .flag_q   (heat_q)
  );

  // overload shutdown, cleared by read only
  event_flag_bit #(.CLEAR_WINS(0)) ovld_i (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_ev   (overload_shutdown),
    .clr_ev   (1'b0),
    .rd_clr   (rd_outp),
    .flag_q   (ovld_q)
  );

  // register images, unassigned bits held at zero
  always @* begin
    acq_v                    = `EVT_RESET;
    acq_v[`ACQ_OVERFLOW_BIT] = ovf_q;
    acq_v[`ACQ_PTT_BIT]      = ptt_q;
    acq_v[`ACQ_AVAIL_BIT]    = avail_q;
    acq_v[`ACQ_AVGDONE_BIT]  = avgdone_q;
    integ_v                  = `EVT_RESET;
    integ_v[`INT_CAL_BIT]    = cal_q;
    outp_v                   = `EVT_RESET;
    outp_v[`OUT_LIMIT_BIT]   = limit_q;
    outp_v[`OUT_TRIP_BIT]    = trip_q;
    outp_v[`OUT_HEAT_BIT]    = heat_q;
    outp_v[`OUT_OVLD_BIT]    = ovld_q;
  end

  // double dabble add-3 step on bcd digits
  always @* begin
    bcd_adj = bcd_q;
    for (i = 0; i < `DEC_DIGITS; i = i + 1) begin
      if (bcd_q[i*4 +: 4] > 4'h4) begin
        bcd_adj[i*4 +: 4] = bcd_q[i*4 +: 4] + 4'h3;
      end
    end
  end

  // query capture, decimal conversion and answer
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q       <= 1'b0;
      sel_q        <= `QSEL_ACQ;
      conv_q       <= 1'b0;
      cnt_q        <= {`CONV_CNT_W{1'b0}};
      shf_q        <= `EVT_RESET;
      bcd_q        <= {`DEC_W{1'b0}};
      answer_valid <= 1'b0;
      answer_bcd   <= {`DEC_W{1'b0}};
      answer_bin   <= `EVT_RESET;
      query_bad    <= 1'b0;
    end else begin
      answer_valid <= 1'b0;
      query_bad    <= 1'b0;
      if (query_valid && !conv_q) begin
        if (query_sel == `QSEL_ACQ || query_sel == `QSEL_INTEG ||
            query_sel == `QSEL_OUTPUT) begin
          pend_q <= 1'b1;
          sel_q  <= query_sel;
        end else begin
          pend_q    <= 1'b0;
          query_bad <= 1'b1;
        end
      end else if (rd_go) begin
        pend_q     <= 1'b0;
        conv_q     <= 1'b1;
        cnt_q      <= {`CONV_CNT_W{1'b0}};
        shf_q      <= snap;
        bcd_q      <= {`DEC_W{1'b0}};
        answer_bin <= snap;
      end else if (conv_q) begin
        if (cnt_q == `CONV_STEPS) begin
          conv_q       <= 1'b0;
          answer_valid <= 1'b1;
          answer_bcd   <= bcd_q;
        end else begin
          bcd_q <= {bcd_adj[`DEC_W-2:0], shf_q[`EVT_W-1]};
          shf_q <= {shf_q[`EVT_W-2:0], 1'b0};
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

endmodule

// one event flag: set and clear events, read clear, set wins over read
module event_flag_bit #(
  // clear event wins over a set in the same cycle when non-zero
  parameter CLEAR_WINS = 0
) (
  // clock and reset
  input  wire core_clk,
  input  wire rstn,
  // set, clear and read-clear strobes
  input  wire set_ev,
  input  wire clr_ev,
  input  wire rd_clr,
  // flag
  output reg  flag_q
);

  reg         flag_d;

  // next value: read clear first, then the events
  always @* begin
    flag_d = flag_q;
    if (rd_clr) begin
      flag_d = 1'b0;
    end
    if (CLEAR_WINS != 0 && clr_ev) begin
      flag_d = 1'b0;
    end else if (set_ev) begin
      flag_d = 1'b1;
    end else if (clr_ev) begin
      flag_d = 1'b0;
    end
  end

  // flag register
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// ==== core/status_event_map.vh ====
// status event register bank: query codes, bit positions, widths
// assumes inclusion by core/status_event_registers.v only
`ifndef STATUS_EVENT_MAP_VH
`define STATUS_EVENT_MAP_VH

// query selector codes
`define QSEL_ACQ          2'h0
`define QSEL_INTEG        2'h1
`define QSEL_OUTPUT       2'h2

// register width and reset value
`define EVT_W             16
`define EVT_RESET         16'h0000

// acquisition register bits
`define ACQ_OVERFLOW_BIT  3
`define ACQ_PTT_BIT       4
`define ACQ_AVAIL_BIT     5
`define ACQ_AVGDONE_BIT   9

// integrity register bits
`define INT_CAL_BIT       8

// output register bits
`define OUT_LIMIT_BIT     3
`define OUT_TRIP_BIT      4
`define OUT_HEAT_BIT      5
`define OUT_OVLD_BIT      6

// decimal answer: five bcd digits
`define DEC_DIGITS        5
`define DEC_W             20
`define CONV_CNT_W        5
`define CONV_STEPS        5'h10

`endif

// ==== verif/status_event_registers_checker.sv ====
// checker: answer timing and value relations of the event register bank
// assumes binding to the status_event_registers ports
`timescale 1ns/100ps
module status_event_registers_checker (
  // clock and reset
  input wire        core_clk,
  input wire        rstn,
  // query and answer
  input wire        query_valid,
  input wire [1:0]  query_sel,
  input wire        talk,
  input wire        answer_valid,
  input wire [19:0] answer_bcd,
  input wire [15:0] answer_bin,
  input wire        query_bad
);
  // decimal digits folded back to binary
  wire [17:0] dec_val = answer_bcd[3:0] + 18'hA * answer_bcd[7:4]
    + 18'h64 * answer_bcd[11:8] + 18'h3E8 * answer_bcd[15:12] + 18'h2710 * answer_bcd[19:16];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_bad; query_bad |-> $past(query_valid) && $past(query_sel) == 2'h3; endproperty
  a_bad: assert property (p_bad) else $error("query_bad without bad query");
  property p_pulse; answer_valid |=> !answer_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer_valid longer than one cycle");
  property p_lat; $rose(answer_valid) |-> $past(talk, 18); endproperty
  a_lat: assert property (p_lat) else $error("answer not 18 cycles after read");
  property p_dec; answer_valid |-> dec_val == {2'h0, answer_bin}; endproperty
  a_dec: assert property (p_dec) else $error("decimal answer differs from binary");
  property p_hold; $changed(answer_bcd) |-> answer_valid; endproperty
  a_hold: assert property (p_hold) else $error("answer_bcd changed outside answer");
  property p_rd; $changed(answer_bin) |-> $past(talk); endproperty
  a_rd: assert property (p_rd) else $error("answer_bin changed without read");
  property p_stab; answer_valid |-> $stable(answer_bin); endproperty
  a_stab: assert property (p_stab) else $error("answer_bin moved during conversion");
  property p_unused; answer_valid |-> (answer_bin & 16'hFC87) == 16'h0000; endproperty
  a_unused: assert property (p_unused) else $error("unassigned bit set");
endmodule

// ==== verif/host_query_model.sv ====
// host model: status queries, answer decoded from decimal digits
// assumes strobes change 1 ns after the core_clk edge
`timescale 1ns/100ps
module host_query_model (
  // clock and answer
  input  wire        core_clk,
  input  wire        answer_valid,
  input  wire [19:0] answer_bcd,
  // query strobes
  output reg         query_valid = 1'b0,
  output reg  [1:0]  query_sel = 2'h0,
  output reg         talk = 1'b0
);
  task step(input q, input [1:0] s, input t);
    begin
      @(posedge core_clk) #1;
      query_valid = q;
      query_sel   = s;
      talk        = t;
    end
  endtask
  // query, talk, then bounded wait; bit 16 set means no answer
  task ask(input [1:0] s, output [16:0] v);
    integer n;
    begin
      step(1'b1, s, 1'b0);
      step(1'b0, ~s, 1'b1);
      step(1'b0, s, 1'b0);
      v = 17'h10000;
      for (n = 0; n < 40 && v[16]; n = n + 1) begin
        @(posedge core_clk) #1;
        if (answer_valid)
          v = answer_bcd[3:0] + 17'hA * answer_bcd[7:4] + 17'h64 * answer_bcd[11:8]
            + 17'h3E8 * answer_bcd[15:12] + 17'h2710 * answer_bcd[19:16];
      end
    end
  endtask
endmodule

// ==== verif/tb_status_event_registers.sv ====
// testbench: event set and read-clear sequences through the host model
// assumes checker and host model compiled first
`timescale 1ns/100ps
module tb_status_event_registers;
  reg         core_clk;
  reg         rstn = 1'b0;
  reg  [10:0] ev = 11'h000;
  wire        query_valid, talk, answer_valid, query_bad;
  wire [1:0]  query_sel;
  wire [19:0] answer_bcd;
  wire [15:0] answer_bin;
  integer     bad_count = 0;
  integer     checks_done = 0;
  reg  [16:0] v;
  status_event_registers dut (.core_clk(core_clk), .rstn(rstn),
    .reading_overflow(ev[0]), .pulse_trigger_timeout(ev[1]), .reading_available(ev[2]),
    .average_count_done(ev[3]), .cal_invalid_at_powerup(ev[4]), .cal_success(ev[5]),
    .current_limiting(ev[6]), .limit_trip_off(ev[7]), .heat_sink_shutdown(ev[8]),
    .overload_shutdown(ev[9]), .output_reenable(ev[10]), .query_valid(query_valid),
    .query_sel(query_sel), .talk(talk), .answer_valid(answer_valid),
    .answer_bcd(answer_bcd), .answer_bin(answer_bin), .query_bad(query_bad));
  host_query_model host (.core_clk(core_clk), .answer_valid(answer_valid),
    .answer_bcd(answer_bcd), .query_valid(query_valid), .query_sel(query_sel), .talk(talk));
  task tally_and_finish;
    begin
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [1:0] s, input [15:0] e);
    begin
      host.ask(s, v);
      checks_done = checks_done + 1;
      if (v !== {1'b0, e}) begin
        bad_count = bad_count + 1;
        $display("FAIL register %0d expected %0d seen %0d", s, e, v);
        if (v[16]) tally_and_finish;
      end
    end
  endtask
  task pulse(input [10:0] m);
    begin
      ev = ev | m;
      @(posedge core_clk) #1;
      ev = ev & ~m;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'b1;
    chk(2'h0, 16'h0000);
    chk(2'h1, 16'h0000);
    host.step(1'b1, 2'h3, 1'b0);
    host.step(1'b0, 2'h0, 1'b0);
    checks_done = checks_done + 1;
    if (query_bad !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("FAIL query_bad expected 1 seen %0b", query_bad);
    end
    chk(2'h2, 16'h0000);
    pulse(11'h00F);
    chk(2'h0, 16'h0238);
    chk(2'h0, 16'h0000);
    pulse(11'h010);
    chk(2'h1, 16'h0100);
    pulse(11'h010);
    pulse(11'h020);
    chk(2'h1, 16'h0000);
    ev[6] = 1'b1;
    pulse(11'h380);
    chk(2'h2, 16'h0078);
    chk(2'h2, 16'h0008);
    ev[6] = 1'b0;
    pulse(11'h180);
    pulse(11'h400);
    chk(2'h2, 16'h0000);
    fork
      host.ask(2'h0, v);
      begin
        @(posedge talk) ev[2] = 1'b1;
        @(posedge core_clk) #1 ev[2] = 1'b0;
      end
    join
    chk(2'h0, 16'h0020);
    tally_and_finish;
  end
endmodule
bind status_event_registers status_event_registers_checker chk_i (.core_clk(core_clk),
  .rstn(rstn), .query_valid(query_valid), .query_sel(query_sel), .talk(talk),
  .answer_valid(answer_valid), .answer_bcd(answer_bcd), .answer_bin(answer_bin),
  .query_bad(query_bad));
